// *** hdl/licc_top.sv ***
// lin interface configuration, checksum, response timing and sleep control
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R1: baud writes from 2400 to 20000 are accepted, others refused
// R2: divisor is 1500000 over rate, rounded to nearest
// R3: warning when derived rate is off by more than half a percent
// R4: checksum type 0 sums data bytes only
// R5: checksum type 1 adds the identifier byte too
// R6: length check off ends header response by eight-byte timeout
// R7: length check on ends response after length-code data bytes
// R8: length check off spaces headers by header, eight bytes, checksum, gap
// R9: length check on spaces headers by header, length bytes, checksum, gap
// R10: length check on refuses header length outside one to eight
// R11: length check touches only header requests
// R12: wakeup always a state; logged as frame when logging set
// R13: response timeout lengthened by programmed 50 us units
// R14: powers up awake with sleep cleared
// R15: host may set sleep at any time while awake
// R16: four seconds of bus silence flags a sleep condition
// R17: while asleep, host or wakeup logic clears sleep
// R18: bit timing divides a 1.5 MHz tick by the divisor
// R19: reset returns every setting to zero
module licc_top #(
  parameter int IDLE_CYC = licc_pkg::SLEEP_IDLE_CYC,
  parameter int UNIT_CYC = licc_pkg::EXT_UNIT_CYC,
  parameter int IFS_BITS = licc_pkg::IFS_BITS_DEF
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [licc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [licc_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [licc_pkg::DATA_W-1:0] rdata_o,
  input wire logic lin_rx_i,
  input wire licc_pkg::licc_req_t req_i,
  output logic req_ready_o,
  output logic req_taken_o,
  output logic req_bad_o,
  input wire licc_pkg::licc_byte_t byte_i,
  output logic [7:0] checksum_o,
  output logic bit_tick_o,
  output logic eor_o,
  output logic rsp_timeout_o,
  output logic sleep_o,
  output logic sleep_cond_o,
  output logic wake_frame_o
);
  import licc_pkg::*;
  localparam int IW = $clog2(IDLE_CYC + 1);
  localparam int UW = $clog2(UNIT_CYC + 1);
  // ***********************
  // register bus decode
  // ***********************
  logic [3:0] ctrl_reg;
  logic [14:0] baud_reg;
  logic [9:0] div_reg;
  logic [15:0] rspto_reg;
  logic warn_reg, rerr_reg, wake_reg, idle_reg;
  logic [31:0] rdata_reg;
  licc_state_t st_reg, st_next;
  wire wr_ctrl = wr_i && addr_i == OFS_CTRL;
  wire wr_baud = wr_i && addr_i == OFS_BAUD;
  wire wr_rspto = wr_i && addr_i == OFS_RSPTO;
  wire wr_stat = wr_i && addr_i == OFS_STAT;
  wire [14:0] wrate = wdata_i[14:0];
  wire rate_ok = wdata_i[31:15] == 17'h0 && 32'(wrate) >= BAUD_MIN && 32'(wrate) <= BAUD_MAX;
  wire chk_type = ctrl_reg[CTRL_CHK];
  wire len_chk = ctrl_reg[CTRL_LEN];
  wire log_wake = ctrl_reg[CTRL_LOGW];
  wire [4:0] stat_word = {st_reg != S_IDLE, idle_reg, wake_reg, rerr_reg, warn_reg};
  wire [31:0] rd_mux = (addr_i == OFS_CTRL) ? {28'h0, ctrl_reg} :
                       (addr_i == OFS_BAUD) ? {17'h0, baud_reg} :
                       (addr_i == OFS_DIV) ? {22'h0, div_reg} :
                       (addr_i == OFS_RSPTO) ? {16'h0, rspto_reg} :
                       (addr_i == OFS_STAT) ? {27'h0, stat_word} : 32'h0;
  // ***********************
  // pin sync, idle and wake
  // ***********************
  logic rx_s1, rx_s2, rx_prev;
  logic [IW-1:0] idle_cnt;
  logic sleep_cond_reg, wake_frame_reg;
  wire rx_edge = rx_s2 != rx_prev;
  wire idle_hit = !ctrl_reg[CTRL_SLEEP] && idle_cnt == IW'(IDLE_CYC - 1);
  wire wake_ev = ctrl_reg[CTRL_SLEEP] && rx_prev && !rx_s2;
  wire sleep_next = wake_ev ? 1'b0 : (wr_ctrl ? wdata_i[CTRL_SLEEP] : ctrl_reg[CTRL_SLEEP]);
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_s1 <= lin_rx_i;
      rx_s2 <= rx_s1;
      rx_prev <= rx_s2;
    end
  end
  always_ff @(posedge clock_i) begin
    if (reset_i || rx_edge || ctrl_reg[CTRL_SLEEP]) begin
      idle_cnt <= '0;
    end else if (idle_cnt != IW'(IDLE_CYC)) begin
      idle_cnt <= idle_cnt + IW'(1); // [R16]
    end
  end
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ctrl_reg <= CTRL_RST; // [R14] [R19]
      baud_reg <= BAUD_RST;
      div_reg <= DIV_RST;
      rspto_reg <= RSPTO_RST;
      warn_reg <= 1'b0;
      rerr_reg <= 1'b0;
      wake_reg <= 1'b0;
      idle_reg <= 1'b0;
      rdata_reg <= 32'h0;
      sleep_cond_reg <= 1'b0;
      wake_frame_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg[2:0] <= wdata_i[2:0];
      end
      ctrl_reg[CTRL_SLEEP] <= sleep_next; // [R15] [R17]
      if (wr_baud && rate_ok) begin
        baud_reg <= wrate; // [R1]
        div_reg <= baud_div(wrate); // [R2]
        warn_reg <= dev_warn(wrate, baud_div(wrate)); // [R3]
        rerr_reg <= 1'b0;
      end else if (wr_baud) begin
        rerr_reg <= 1'b1; // [R1]
      end
      if (wr_rspto) begin
        rspto_reg <= wdata_i[15:0];
      end
      wake_reg <= wake_ev || (wake_reg && !(wr_stat && wdata_i[ST_WAKE])); // [R12]
      idle_reg <= idle_hit || (idle_reg && !(wr_stat && wdata_i[ST_IDLE])); // [R16]
      sleep_cond_reg <= idle_hit; // [R16]
      wake_frame_reg <= wake_ev && log_wake; // [R12]
      rdata_reg <= rd_i ? rd_mux : 32'h0;
    end
  end
  // ***********************
  // bit timing
  // ***********************
  logic [7:0] ref_acc;
  logic ref_tick;
  logic [9:0] bit_cnt;
  logic bit_tick_reg;
  wire [7:0] acc_sum = ref_acc + REF_NUM;
  wire bit_hit = ref_tick && div_reg != 10'h0 && bit_cnt >= div_reg - 10'd1;
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ref_acc <= 8'h0;
      ref_tick <= 1'b0;
      bit_cnt <= 10'h0;
      bit_tick_reg <= 1'b0;
    end else begin
      ref_acc <= (acc_sum >= REF_DEN) ? acc_sum - REF_DEN : acc_sum; // [R18]
      ref_tick <= acc_sum >= REF_DEN;
      if (wr_baud || bit_hit) begin
        bit_cnt <= 10'h0;
      end else if (ref_tick) begin
        bit_cnt <= bit_cnt + 10'd1; // [R18]
      end
      bit_tick_reg <= bit_hit;
    end
  end
  // ***********************
  // checksum
  // ***********************
  logic [7:0] sum_reg;
  logic [7:0] chk_reg;
  wire use_byte = byte_i.valid && (!byte_i.is_id || chk_type); // [R4] [R5]
  wire [7:0] sum_base = byte_i.start ? 8'h0 : sum_reg;
  wire [7:0] sum_next = use_byte ? add8(sum_base, byte_i.data) : sum_base;
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sum_reg <= 8'h0;
      chk_reg <= 8'hff;
    end else if (byte_i.valid) begin
      sum_reg <= sum_next;
      chk_reg <= ~sum_next;
    end
  end
  // ***********************
  // header response timing
  // ***********************
  logic [7:0] tbits;
  logic [7:0] limit_reg;
  logic [3:0] nbytes, len_reg;
  logic [15:0] units;
  logic [UW-1:0] ucyc;
  logic ready_reg, taken_reg, bad_reg, eor_reg, tout_reg;
  wire is_hdr = req_i.frame_request_type == REQ_HDR;
  wire take = req_i.valid && ready_reg;
  wire len_bad = len_chk && (req_i.len == 4'h0 || req_i.len > MAX_DATA); // [R10]
  wire hdr_go = take && is_hdr && !len_bad; // [R11]
  wire data_in = byte_i.valid && !byte_i.is_id;
  wire [3:0] nb_next = data_in ? nbytes + 4'd1 : nbytes;
  wire len_done = len_chk && nb_next >= len_reg; // [R7]
  wire bits_out = bit_tick_reg && tbits >= limit_reg - 8'd1;
  wire unit_end = ucyc == UW'(UNIT_CYC - 1);
  wire ext_out = units >= rspto_reg || (unit_end && units + 16'd1 >= rspto_reg); // [R13]
  wire ifs_done = bit_tick_reg && 32'(tbits) >= IFS_BITS - 1;
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      S_IDLE: if (hdr_go) st_next = S_WAIT;
      S_WAIT: if (len_done) st_next = S_IFS;
              else if (bits_out) st_next = S_EXTRA; // [R6]
      S_EXTRA: if (len_done || ext_out) st_next = S_IFS; // [R13]
      S_IFS: if (ifs_done) st_next = S_IDLE; // [R8] [R9]
    endcase
  end
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_reg <= S_IDLE;
      tbits <= 8'h0;
      limit_reg <= 8'h0;
      nbytes <= 4'h0;
      len_reg <= 4'h0;
      units <= 16'h0;
      ucyc <= '0;
      ready_reg <= 1'b0;
      taken_reg <= 1'b0;
      bad_reg <= 1'b0;
      eor_reg <= 1'b0;
      tout_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ready_reg <= st_next == S_IDLE;
      taken_reg <= take && !(is_hdr && len_bad); // [R11]
      bad_reg <= take && is_hdr && len_bad; // [R10]
      eor_reg <= st_reg != S_IFS && st_next == S_IFS;
      tout_reg <= st_reg == S_EXTRA && ext_out && len_chk && !len_done; // [R13]
      if (hdr_go) begin
        len_reg <= len_chk ? req_i.len : MAX_DATA; // [R6] [R10]
        limit_reg <= rsp_limit(len_chk ? req_i.len : MAX_DATA); // [R8] [R9]
      end
      nbytes <= (st_reg == S_IDLE) ? 4'h0 : nb_next;
      if (st_next != st_reg) begin
        tbits <= 8'h0;
      end else if (bit_tick_reg) begin
        tbits <= tbits + 8'd1;
      end
      ucyc <= (st_reg != S_EXTRA || unit_end) ? '0 : ucyc + UW'(1);
      if (st_reg != S_EXTRA) begin
        units <= 16'h0;
      end else if (unit_end) begin
        units <= units + 16'd1; // [R13]
      end
    end
  end
  // ***********************
  // outputs
  // ***********************
  assign rdata_o = rdata_reg;
  assign req_ready_o = ready_reg;
  assign req_taken_o = taken_reg;
  assign req_bad_o = bad_reg;
  assign checksum_o = chk_reg;
  assign bit_tick_o = bit_tick_reg;
  assign eor_o = eor_reg;
  assign rsp_timeout_o = tout_reg;
  assign sleep_o = ctrl_reg[CTRL_SLEEP];
  assign sleep_cond_o = sleep_cond_reg;
  assign wake_frame_o = wake_frame_reg;
  // ***********************
  // assertions
  // ***********************
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  a_baud_refused: assert property (wr_baud && !rate_ok |=> $stable(baud_reg) && rerr_reg) // [R1]
    else $error("out of range rate was taken");
  a_div_rounded: assert property (wr_baud && rate_ok |=> div_reg == baud_div($past(wrate))) // [R2]
    else $error("divisor not rounded rate");
  a_warn_set: assert property (wr_baud && rate_ok |=> warn_reg == dev_warn(baud_reg, div_reg)) // [R3]
    else $error("deviation warning wrong");
  a_classic_sum: assert property (byte_i.valid && byte_i.is_id && !chk_type // [R4]
    |=> sum_reg == ($past(byte_i.start) ? 8'h0 : $past(sum_reg)))
    else $error("id byte summed in classic mode");
  a_enh_sum: assert property (byte_i.valid && byte_i.is_id && chk_type // [R5]
    |=> sum_reg == add8($past(byte_i.start) ? 8'h0 : $past(sum_reg), $past(byte_i.data)))
    else $error("id byte missing from enhanced sum");
  a_len_end: assert property (st_reg == S_WAIT && len_done |=> eor_reg && st_reg == S_IFS) // [R7]
    else $error("response not ended at length code");
  a_len_refuse: assert property (take && is_hdr && len_bad |=> bad_reg && st_reg == S_IDLE) // [R10]
    else $error("bad header length accepted");
  a_other_kind: assert property (take && !is_hdr |=> taken_reg && st_reg == S_IDLE) // [R11]
    else $error("full or response request mishandled");
  a_wake_log: assert property (wake_ev |=> !sleep_o && wake_reg && wake_frame_o == $past(log_wake)) // [R12]
    else $error("wakeup not reported");
  a_idle_sleep: assert property (idle_hit |=> sleep_cond_o ##1 !sleep_cond_o) // [R16]
    else $error("idle sleep condition not pulsed");
  a_hdr_busy: assert property (hdr_go |=> !req_ready_o && st_reg == S_WAIT) // [R8] [R9]
    else $error("header taken but ready stayed high");
  a_eor_pulse: assert property (eor_o |=> !eor_o) // [R7]
    else $error("end of response longer than one cycle");
  a_tick_pulse: assert property (bit_tick_o |=> !bit_tick_o) // [R18]
    else $error("bit tick longer than one cycle");
  c_bad_len: cover property (req_bad_o);
  c_header_len: cover property (take && is_hdr && len_chk ##[1:300] eor_reg);
  c_extra_wait: cover property (st_reg == S_EXTRA ##1 st_reg == S_IFS);
  c_wake_frame: cover property (wake_frame_o);
endmodule
`default_nettype wire

// *** hdl/licc_pkg.sv ***
// constants, types and helpers of the lin interface config and control block
package licc_pkg;
  // ***********************
  // register map
  // ***********************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BAUD = 8'h04;
  localparam logic [7:0] OFS_DIV = 8'h08;
  localparam logic [7:0] OFS_RSPTO = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam int CTRL_CHK = 0;
  localparam int CTRL_LEN = 1;
  localparam int CTRL_LOGW = 2;
  localparam int CTRL_SLEEP = 3;
  localparam int ST_WARN = 0;
  localparam int ST_RERR = 1;
  localparam int ST_WAKE = 2;
  localparam int ST_IDLE = 3;
  localparam int ST_BUSY = 4;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [14:0] BAUD_RST = 15'h0;
  localparam logic [9:0] DIV_RST = 10'h0;
  localparam logic [15:0] RSPTO_RST = 16'h0;
  // ***********************
  // rates and timing
  // ***********************
  localparam int BAUD_MIN = 2400;
  localparam int BAUD_MAX = 20000;
  localparam int REF_HZ = 1500000;
  localparam int DEV_DEN = 200;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [7:0] REF_DEN = 8'd200;
  localparam logic [7:0] REF_NUM = 8'(64'(REF_HZ) * CLK_PERIOD_NS * REF_DEN / 64'd1000000000);
  localparam int EXT_UNIT_US = 50;
  localparam int EXT_UNIT_CYC = EXT_UNIT_US * 1000 / CLK_PERIOD_NS;
  localparam int SLEEP_IDLE_S = 4;
  localparam int SLEEP_IDLE_CYC = int'(64'(SLEEP_IDLE_S) * 64'd1000000000 / CLK_PERIOD_NS);
  localparam logic [7:0] HDR_BITS = 8'd34;
  localparam logic [7:0] TO_BITS_PER_BYTE = 8'd14;
  localparam logic [3:0] MAX_DATA = 4'd8;
  localparam int IFS_BITS_DEF = 10;
  // ***********************
  // types
  // ***********************
  typedef enum logic [1:0] {
    REQ_FULL = 2'b00,
    REQ_RESP = 2'b01,
    REQ_HDR = 2'b10
  } licc_kind_t;
  typedef struct packed {
    logic valid;
    licc_kind_t frame_request_type;
    logic [3:0] len;
  } licc_req_t;
  typedef struct packed {
    logic valid;
    logic start;
    logic is_id;
    logic [7:0] data;
  } licc_byte_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_WAIT = 2'b01,
    S_EXTRA = 2'b10,
    S_IFS = 2'b11
  } licc_state_t;
  // ***********************
  // helpers
  // ***********************
  function automatic logic [9:0] baud_div(input logic [14:0] rate);
    logic [31:0] q;
    q = (32'(REF_HZ) + {18'h0, rate[14:1]}) / {17'h0, rate};
    return q[9:0];
  endfunction
  function automatic logic dev_warn(input logic [14:0] rate, input logic [9:0] div);
    logic [31:0] prod;
    logic [31:0] diff;
    prod = {17'h0, rate} * {22'h0, div};
    diff = (prod > 32'(REF_HZ)) ? prod - 32'(REF_HZ) : 32'(REF_HZ) - prod;
    return (64'(diff) * DEV_DEN) > 64'(prod);
  endfunction
  function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0] + {7'h0, s[8]};
  endfunction
  function automatic logic [7:0] rsp_limit(input logic [3:0] n);
    return HDR_BITS + TO_BITS_PER_BYTE * ({4'h0, n} + 8'd1);
  endfunction
endpackage

// *** dv/licc_lin_node.sv ***
// far-side lin node model: bus level and slave response bytes
`timescale 1ns/1ps
`default_nettype none
module licc_lin_node (
  input wire logic clock_i,
  output logic lin_rx_o,
  output licc_pkg::licc_byte_t byte_o
);
  import licc_pkg::*;
  initial begin
    lin_rx_o = 1'b1;
    byte_o = '0;
  end
  // one byte, then gap idle cycles; released data shows the inverse
  task automatic send(input logic is_id, input logic start, input logic [7:0] d, input int gap);
    @(posedge clock_i);
    byte_o <= '{1'b1, start, is_id, d};
    @(posedge clock_i);
    byte_o <= '{1'b0, 1'b0, 1'b0, ~d};
    repeat (gap) @(posedge clock_i);
  endtask
  // dominant pulse on the recessive bus wakes a sleeping node
  task automatic wake(input int len);
    @(posedge clock_i);
    lin_rx_o <= 1'b0;
    repeat (len) @(posedge clock_i);
    lin_rx_o <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench of the lin config and control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: %s", $time, m); end end
module tb;
  import licc_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic lin_rx;
  licc_req_t req_i = '0;
  licc_byte_t byte_i;
  logic req_ready_o, req_taken_o, req_bad_o, bit_tick_o, eor_o, rsp_timeout_o;
  logic sleep_o, sleep_cond_o, wake_frame_o;
  logic [7:0] checksum_o_w;
  logic tout_seen = 1'b0;
  wire logic [5:0] ev;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic rd_seen = 1'b0;
  int errors = 0;
  int tests_run = 0;
  int seed = 336;
  int r, prev, dv, pr, t;
  logic w, f;
  logic [7:0] d, s;
  logic [8:0] s9;
  localparam logic [7:0] RA[7] = '{OFS_CTRL, OFS_BAUD, OFS_DIV, OFS_RSPTO, OFS_STAT, 8'h14, 8'hfc};
  int rates[7] = '{2399, 2400, 19600, 20001, 0, 9600, 20000};
  assign ev = {wake_frame_o, sleep_cond_o, eor_o, req_bad_o, req_taken_o, bit_tick_o};
  licc_top #(.IDLE_CYC(200), .UNIT_CYC(10), .IFS_BITS(10)) u_dut (
    .clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .lin_rx_i(lin_rx), .req_i(req_i),
    .req_ready_o(req_ready_o), .req_taken_o(req_taken_o), .req_bad_o(req_bad_o),
    .byte_i(byte_i), .checksum_o(checksum_o_w), .bit_tick_o(bit_tick_o), .eor_o(eor_o),
    .rsp_timeout_o(rsp_timeout_o), .sleep_o(sleep_o), .sleep_cond_o(sleep_cond_o),
    .wake_frame_o(wake_frame_o));
  licc_lin_node u_node (.clock_i(clock_i), .lin_rx_o(lin_rx), .byte_o(byte_i));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  // ***********************
  // read result monitor
  // ***********************
  always @(posedge clock_i) begin
    if (rd_seen) begin
      `CHK(rdata_o & msk_q.pop_front(), exp_q.pop_front(), "register read")
    end
    rd_seen <= rd_i;
    if (rsp_timeout_o === 1'b1) tout_seen <= 1'b1;
  end
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic bus(input logic wn, input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= wn;
    rd_i <= !wn;
    if (!wn) begin
      exp_q.push_back(v & m);
      msk_q.push_back(m);
    end
    @(posedge clock_i);
  endtask
  task automatic idle(input int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge clock_i);
  endtask
  task automatic wait_ev(input int k, input int n, input logic must, output logic fd, output int c);
    fd = 1'b0;
    for (c = 0; c < n && !fd; c++) begin
      #1;
      fd = (ev[k] === 1'b1);
      @(posedge clock_i);
    end
    if (must && !fd) begin
      errors++;
      $display("wrong value at %0t: no event %0d", $time, k);
      test_done();
    end
  endtask
  task automatic req(input licc_kind_t k, input logic [3:0] n, input int e, input logic rdy);
    req_i <= '{1'b1, k, n};
    @(posedge clock_i);
    req_i <= '0;
    wait_ev(e, 3, 1'b1, f, t);
    `CHK(req_ready_o, rdy, "ready after request")
  endtask
  task automatic chk_rst;
    foreach (RA[i]) bus(1'b0, RA[i], 0, (RA[i] == OFS_STAT) ? 32'hfffffff7 : 32'hffffffff);
    idle(2);
  endtask
  initial begin
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    idle(2);
    chk_rst();
    `CHK(sleep_o, 1'b0, "awake after power up")
    bus(1'b1, OFS_RSPTO, 32'hffff, 0);
    bus(1'b0, OFS_RSPTO, 32'hffff, 32'hffffffff);
    prev = 0;
    dv = 0;
    foreach (rates[i]) begin
      r = (i == 4) ? BAUD_MIN + {$random(seed)} % (BAUD_MAX - BAUD_MIN + 1) : rates[i];
      w = (r >= BAUD_MIN && r <= BAUD_MAX);
      if (w) begin
        prev = r;
        dv = (REF_HZ + r / 2) / r;
        pr = r * dv;
        w = ((pr > REF_HZ ? pr - REF_HZ : REF_HZ - pr) * 200 > pr);
      end
      bus(1'b1, OFS_BAUD, r, 0);
      idle(1);
      bus(1'b0, OFS_BAUD, prev, 32'h7fff);
      bus(1'b0, OFS_DIV, dv, 32'h3ff);
      bus(1'b0, OFS_STAT, (prev == r) ? 32'(w) : 2, (prev == r) ? 1 : 2);
    end
    idle(1);
    wait_ev(0, 6000, 1'b1, f, t);
    wait_ev(0, 6000, 1'b1, f, t);
    `CHK(t >= 4999 && t <= 5001, 1'b1, "bit period")
    for (int c = 0; c < 2; c++) begin
      bus(1'b1, OFS_CTRL, c, 0);
      idle(1);
      s = c ? 8'h3c : 8'h00;
      u_node.send(1'b1, 1'b1, 8'h3c, 0);
      for (int j = 0; j < 4; j++) begin
        d = 8'($random(seed));
        u_node.send(1'b0, 1'b0, d, j);
        s9 = {1'b0, s} + {1'b0, d};
        s = s9[7:0] + {7'h0, s9[8]};
      end
      idle(1);
      `CHK(checksum_o_w, ~s, "checksum")
    end
    bus(1'b1, OFS_CTRL, 2, 0);
    idle(1);
    req(REQ_HDR, 0, 2, 1'b1);
    req(REQ_HDR, 9, 2, 1'b1);
    req(REQ_FULL, 0, 1, 1'b1);
    req(REQ_RESP, 15, 1, 1'b1);
    req(REQ_HDR, 3, 1, 1'b0);
    fork
      for (int j = 0; j < 3; j++) u_node.send(1'b0, j == 0, 8'h55, 2);
      wait_ev(3, 40, 1'b1, f, t);
    join
    `CHK(f, 1'b1, "end of response")
    for (t = 0; t < 60000 && req_ready_o !== 1'b1; t++) @(posedge clock_i);
    if (t == 60000) wait_ev(1, 0, 1'b1, f, t);
    `CHK(t >= 45000 && t <= 50001, 1'b1, "header spacing")
    `CHK(tout_seen, 1'b0, "timeout after full length response")
    for (int g = 0; g < 2; g++) begin
      bus(1'b1, OFS_CTRL, 32'h8 | (g << 2), 0);
      idle(1);
      `CHK(sleep_o, 1'b1, "sleep entered")
      fork
        u_node.wake(20);
        wait_ev(5, 15, 1'b0, f, t);
      join
      `CHK(f, 1'(g), "wake frame")
      `CHK(sleep_o, 1'b0, "woken")
      bus(1'b0, OFS_CTRL, g << 2, 32'hf);
      bus(1'b0, OFS_STAT, 4, 4);
      bus(1'b1, OFS_STAT, 4, 0);
      idle(1);
    end
    wait_ev(4, 400, 1'b1, f, t);
    `CHK(t >= 195 && t <= 215, 1'b1, "idle time")
    bus(1'b1, OFS_CTRL, 0, 0);
    idle(1);
    req(REQ_HDR, 0, 1, 1'b0);
    reset_i <= 1'b1;
    idle(3);
    reset_i <= 1'b0;
    idle(2);
    chk_rst();
    test_done();
  end
endmodule
`default_nettype wire
